// [tw_pkg.sv]
// constants, state type and register map of the two-wire master transmitter
package tw_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_DATA = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_MODE = 8'h0C;

	// bus_control field positions
	localparam int CTL_FLAG = 7;
	localparam int CTL_ACKEN = 6;
	localparam int CTL_START = 5;
	localparam int CTL_STOP = 4;
	localparam int CTL_WCOL = 3;
	localparam int CTL_EN = 2;
	localparam int CTL_RSVD = 1;
	localparam int CTL_IRQEN = 0;
	localparam logic [BYTE_W-1:0] CTL_RESET = 8'h00;

	// bus_status layout: code in the upper five bits, prescaler bits below
	localparam int STS_PRESC_W = 2;
	localparam logic [BYTE_W-1:0] STS_CODE_MASK = 8'hF8;
	localparam logic [BYTE_W-1:0] SC_IDLE = 8'hF8;
	localparam logic [BYTE_W-1:0] SC_START = 8'h08;
	localparam logic [BYTE_W-1:0] SC_RSTART = 8'h10;
	localparam logic [BYTE_W-1:0] SC_ADDR_ACK = 8'h18;
	localparam logic [BYTE_W-1:0] SC_ADDR_NACK = 8'h20;
	localparam logic [BYTE_W-1:0] SC_DATA_ACK = 8'h28;
	localparam logic [BYTE_W-1:0] SC_DATA_NACK = 8'h30;
	localparam logic [BYTE_W-1:0] SC_ARB_LOST = 8'h38;

	// operating modes, shown in the mode register
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_MT = 2'h1;
	localparam logic [1:0] MODE_MR = 2'h2;

	// line levels of the direction and acknowledge bits
	localparam logic DIR_READ = 1'b1;
	localparam logic ACK_LEVEL = 1'b0;

	// serial clock timing
	localparam int SCL_HALF_NS = 5000;
	localparam int CLK_NS = 4;
	localparam int SCL_HALF_CYCLES = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [9:0] {
		ST_IDLE = 10'b00_0000_0001,
		ST_WAIT_FREE = 10'b00_0000_0010,
		ST_START = 10'b00_0000_0100,
		ST_LOW = 10'b00_0000_1000,
		ST_HIGH = 10'b00_0001_0000,
		ST_HOLD = 10'b00_0010_0000,
		ST_STOP_LOW = 10'b00_0100_0000,
		ST_STOP_HIGH = 10'b00_1000_0000,
		ST_RS_LOW = 10'b01_0000_0000,
		ST_RS_HIGH = 10'b10_0000_0000
	} tw_state_t;

endpackage

// [tw_sync.sv]
// three-flop input synchroniser, output follows once the last two flops agree
`timescale 1ns/100ps
module tw_sync #(
	parameter int W = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_reg;
			logic mid_reg;
			logic last_reg;
			logic out_reg;
			logic out_next;
			always_comb begin
				out_next = out_reg;
				if (mid_reg == last_reg) begin
					out_next = last_reg;
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_reg <= 1'b1;
					mid_reg <= 1'b1;
					last_reg <= 1'b1;
					out_reg <= 1'b1;
				end else begin
					meta_reg <= async_in[i];
					mid_reg <= meta_reg;
					last_reg <= mid_reg;
					out_reg <= out_next;
				end
			end
			assign sync_out[i] = out_reg;
		end
	endgenerate
endmodule

// [tw_tick.sv]
// half-period timer: pulses done after LIMIT cycles of run, restarts when run drops
`timescale 1ns/100ps
module tw_tick #(
	parameter int unsigned LIMIT = 1250
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	output logic done
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LAST = W'(LIMIT - 1);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	always_comb begin
		cnt_next = cnt_reg;
		done = 1'b0;
		if (!run) begin
			cnt_next = '0;
		end else if (cnt_reg == LAST) begin
			cnt_next = '0;
			done = 1'b1;
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule

// [tw_master.sv]
// two-wire master transmitter with APB register access
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
module tw_master #(
	parameter int unsigned HALF_CYCLES = tw_pkg::SCL_HALF_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tw_pkg::ADDR_W-1:0] paddr,
	input wire logic [tw_pkg::DATA_W-1:0] pwdata,
	output logic [tw_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	import tw_pkg::*;

	tw_state_t state_reg;
	tw_state_t state_next;
	logic [BYTE_W-1:0] ctl_reg;
	logic [BYTE_W-1:0] ctl_next;
	logic [BYTE_W-1:0] status_reg;
	logic [BYTE_W-1:0] status_next;
	logic [STS_PRESC_W-1:0] presc_reg;
	logic [STS_PRESC_W-1:0] presc_next;
	logic [BYTE_W-1:0] data_reg;
	logic [BYTE_W-1:0] data_next;
	logic [BYTE_W-1:0] shift_reg;
	logic [BYTE_W-1:0] shift_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic [1:0] mode_reg;
	logic [1:0] mode_next;
	logic [DATA_W-1:0] prdata_reg;
	logic [DATA_W-1:0] prdata_next;
	logic scl_low_reg;
	logic scl_low_next;
	logic sda_low_reg;
	logic sda_low_next;
	logic busy_reg;
	logic busy_next;
	logic sda_prev_reg;
	logic rep_reg;
	logic rep_next;
	logic addr_phase_reg;
	logic addr_phase_next;
	logic lost_reg;
	logic lost_next;

	logic [1:0] line_s;
	logic scl_s;
	logic sda_s;
	logic timer_run;
	logic timer_done;
	logic wr_access;
	logic rd_setup;
	logic mapped;
	logic hw_set;
	logic [BYTE_W-1:0] hw_code;
	logic acked;
	localparam logic [3:0] ACK_SLOT = 4'(BYTE_W);

	tw_sync #(
		.W(2)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({scl_in, sda_in}),
		.sync_out(line_s)
	);

	assign scl_s = line_s[1];
	assign sda_s = line_s[0];

	// the timer is held in reset while a released clock is still stretched low
	assign timer_run = ((state_reg == ST_START) || (state_reg == ST_LOW) ||
		(state_reg == ST_STOP_LOW) || (state_reg == ST_RS_LOW) ||
		(((state_reg == ST_HIGH) || (state_reg == ST_STOP_HIGH) ||
		(state_reg == ST_RS_HIGH)) && scl_s));

	tw_tick #(
		.LIMIT(HALF_CYCLES)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.run(timer_run),
		.done(timer_done)
	);

	assign wr_access = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign mapped = (paddr == OFF_CONTROL) || (paddr == OFF_STATUS) ||
		(paddr == OFF_DATA) || (paddr == OFF_MODE);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_reg;

	// open-drain lines: only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_low_reg;
	assign sda_oe = sda_low_reg;

	assign acked = (sda_s == ACK_LEVEL);

	always_comb begin
		state_next = state_reg;
		ctl_next = ctl_reg;
		status_next = status_reg;
		presc_next = presc_reg;
		data_next = data_reg;
		shift_next = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		mode_next = mode_reg;
		prdata_next = prdata_reg;
		scl_low_next = scl_low_reg;
		sda_low_next = sda_low_reg;
		busy_next = busy_reg;
		rep_next = rep_reg;
		addr_phase_next = addr_phase_reg;
		lost_next = lost_reg;
		hw_set = 1'b0;
		hw_code = status_reg;

		// bus busy between a START and a STOP seen on the lines
		if (scl_s && sda_prev_reg && !sda_s) begin
			busy_next = 1'b1;
		end else if (scl_s && !sda_prev_reg && sda_s) begin
			busy_next = 1'b0;
		end

		if (rd_setup) begin
			case (paddr)
				OFF_CONTROL: prdata_next = {24'h00_0000, ctl_reg};
				OFF_STATUS: prdata_next = {24'h00_0000, status_reg & STS_CODE_MASK} |
					{30'h0000_0000, presc_reg};
				OFF_DATA: prdata_next = {24'h00_0000, data_reg};
				OFF_MODE: prdata_next = {30'h0000_0000, mode_reg};
				default: prdata_next = '0;
			endcase
		end

		if (wr_access) begin
			case (paddr)
				OFF_CONTROL: begin
					ctl_next[CTL_ACKEN] = pwdata[CTL_ACKEN];
					ctl_next[CTL_START] = pwdata[CTL_START];
					ctl_next[CTL_STOP] = pwdata[CTL_STOP];
					ctl_next[CTL_EN] = pwdata[CTL_EN];
					ctl_next[CTL_IRQEN] = pwdata[CTL_IRQEN];
					if (pwdata[CTL_FLAG]) begin
						ctl_next[CTL_FLAG] = 1'b0;
					end
				end
				OFF_STATUS: presc_next = pwdata[STS_PRESC_W-1:0];
				OFF_DATA: begin
					if (ctl_reg[CTL_FLAG]) begin
						data_next = pwdata[BYTE_W-1:0];
						ctl_next[CTL_WCOL] = 1'b0;
					end else begin
						ctl_next[CTL_WCOL] = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		case (state_reg)
			ST_IDLE: begin
				scl_low_next = 1'b0;
				sda_low_next = 1'b0;
				if (ctl_reg[CTL_START] && !ctl_reg[CTL_FLAG]) begin
					state_next = ST_WAIT_FREE;
				end
			end
			ST_WAIT_FREE: begin
				if (!busy_reg) begin
					state_next = ST_START;
					rep_next = 1'b0;
					mode_next = MODE_IDLE;
				end
			end
			ST_START: begin
				sda_low_next = 1'b1;
				if (timer_done) begin
					hw_set = 1'b1;
					hw_code = rep_reg ? SC_RSTART : SC_START;
					addr_phase_next = 1'b1;
					scl_low_next = 1'b1;
					state_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!ctl_reg[CTL_FLAG]) begin
					if (lost_reg) begin
						lost_next = 1'b0;
						scl_low_next = 1'b0;
						sda_low_next = 1'b0;
						state_next = ctl_reg[CTL_START] ? ST_WAIT_FREE : ST_IDLE;
					end else if (ctl_reg[CTL_STOP]) begin
						state_next = ST_STOP_LOW;
					end else if (ctl_reg[CTL_START]) begin
						state_next = ST_RS_LOW;
					end else begin
						shift_next = data_reg;
						bit_cnt_next = '0;
						state_next = ST_LOW;
						if (addr_phase_reg) begin
							// either direction is accepted after any START
							mode_next = (data_reg[0] == DIR_READ) ? MODE_MR : MODE_MT;
						end
					end
				end
			end
			ST_LOW: begin
				scl_low_next = 1'b1;
				// data bits first, then release for the acknowledge slot
				sda_low_next = (bit_cnt_reg < ACK_SLOT) ? !shift_reg[BYTE_W-1] : 1'b0;
				if (timer_done) begin
					scl_low_next = 1'b0;
					state_next = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (scl_s && (bit_cnt_reg < ACK_SLOT) && !sda_low_reg && !sda_s) begin
					hw_set = 1'b1;
					hw_code = SC_ARB_LOST;
					lost_next = 1'b1;
					sda_low_next = 1'b0;
					scl_low_next = 1'b0;
					mode_next = MODE_IDLE;
					state_next = ST_HOLD;
				end else if (timer_done) begin
					scl_low_next = 1'b1;
					if (bit_cnt_reg == ACK_SLOT) begin
						hw_set = 1'b1;
						if (addr_phase_reg) begin
							hw_code = acked ? SC_ADDR_ACK : SC_ADDR_NACK;
						end else begin
							hw_code = acked ? SC_DATA_ACK : SC_DATA_NACK;
						end
						addr_phase_next = 1'b0;
						state_next = ST_HOLD;
					end else begin
						shift_next = {shift_reg[BYTE_W-2:0], 1'b0};
						bit_cnt_next = bit_cnt_reg + 4'h1;
						state_next = ST_LOW;
					end
				end
			end
			ST_STOP_LOW: begin
				scl_low_next = 1'b1;
				sda_low_next = 1'b1;
				if (timer_done) begin
					scl_low_next = 1'b0;
					state_next = ST_STOP_HIGH;
				end
			end
			ST_STOP_HIGH: begin
				if (timer_done) begin
					sda_low_next = 1'b0;
					ctl_next[CTL_STOP] = 1'b0;
					mode_next = MODE_IDLE;
					// a start request still set restarts from idle once the bus frees
					state_next = ST_IDLE;
				end
			end
			ST_RS_LOW: begin
				scl_low_next = 1'b1;
				sda_low_next = 1'b0;
				if (timer_done) begin
					scl_low_next = 1'b0;
					state_next = ST_RS_HIGH;
				end
			end
			ST_RS_HIGH: begin
				if (timer_done) begin
					rep_next = 1'b1;
					state_next = ST_START;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase

		// a hardware set wins over a software clear in the same cycle
		if (hw_set) begin
			ctl_next[CTL_FLAG] = 1'b1;
			status_next = hw_code;
		end

		if (!ctl_reg[CTL_EN]) begin
			state_next = ST_IDLE;
			scl_low_next = 1'b0;
			sda_low_next = 1'b0;
			mode_next = MODE_IDLE;
			lost_next = 1'b0;
		end
		ctl_next[CTL_RSVD] = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			ctl_reg <= CTL_RESET;
			status_reg <= SC_IDLE;
			presc_reg <= '0;
			data_reg <= '0;
			shift_reg <= '0;
			bit_cnt_reg <= '0;
			mode_reg <= MODE_IDLE;
			prdata_reg <= '0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			busy_reg <= 1'b0;
			sda_prev_reg <= 1'b1;
			rep_reg <= 1'b0;
			addr_phase_reg <= 1'b0;
			lost_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ctl_reg <= ctl_next;
			status_reg <= status_next;
			presc_reg <= presc_next;
			data_reg <= data_next;
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			mode_reg <= mode_next;
			prdata_reg <= prdata_next;
			scl_low_reg <= scl_low_next;
			sda_low_reg <= sda_low_next;
			busy_reg <= busy_next;
			sda_prev_reg <= sda_s;
			rep_reg <= rep_next;
			addr_phase_reg <= addr_phase_next;
			lost_reg <= lost_next;
		end
	end
endmodule

// [tw_master_props.sv]
// port-level assertions for the two-wire master transmitter
`timescale 1ns/100ps
module tw_props #(
	parameter int unsigned HALF_CYCLES = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tw_pkg::ADDR_W-1:0] paddr,
	input wire logic [tw_pkg::DATA_W-1:0] pwdata,
	input wire logic [tw_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe
);
	import tw_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic cw;
	logic rd;
	logic hold;
	logic known;
	assign cw = psel && penable && pwrite && paddr == OFF_CONTROL;
	assign rd = psel && penable && !pwrite;
	assign known = paddr == OFF_CONTROL || paddr == OFF_STATUS || paddr == OFF_DATA ||
		paddr == OFF_MODE;
	// clock held low longer than any bit half means the transfer is parked
	assign hold = cnt_reg > HALF_CYCLES + 3;
	always_comb begin
		cnt_next = cnt_reg;
		if (cw || !scl_oe) begin
			cnt_next = 8'h00;
		end else if (cnt_reg != 8'hFF) begin
			cnt_next = cnt_reg + 8'h01;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
	sequence dis_wr;
		cw && !pwdata[CTL_EN];
	endsequence
	sequence lines_free;
		(!scl_oe && !sda_oe) [*4];
	endsequence
	AST_SLVERR: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access phase");
	AST_READY: assert property (psel && penable |-> pready)
		else $error("access phase not completed");
	AST_DISABLE: assert property (dis_wr |-> ##2 lines_free)
		else $error("lines driven while disabled");
	AST_RSVD: assert property (rd && paddr == OFF_CONTROL |-> !prdata[CTL_RSVD])
		else $error("reserved control bit reads one");
	AST_STS: assert property (rd && paddr == OFF_STATUS |-> !prdata[2])
		else $error("status bit two reads one");
	AST_HOLD: assert property (hold && !cw |=> scl_oe)
		else $error("clock released while suspended");
	AST_BYTE: assert property (rd |-> prdata[31:8] == 24'h00_0000)
		else $error("read data above one byte");
	AST_OPEN: assert property (!scl_out && !sda_out)
		else $error("line driven high");
	AST_UNMAPPED: assert property (psel && penable && !known |-> pslverr)
		else $error("unmapped access without slave error");
endmodule
bind tw_master tw_props #(.HALF_CYCLES(HALF_CYCLES)) props_u (.*);

// [tw_slave.sv]
// behavioural slave receiver on the two-wire bus
`timescale 1ns/100ps
module tw_slave (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	output logic pull,
	output logic [7:0] rx_byte,
	output int rx_cnt
);
	logic [7:0] sh;
	int bitn;
	logic act;
	initial begin
		pull = 1'b0;
		act = 1'b0;
		bitn = 0;
		rx_cnt = 0;
		rx_byte = 8'h00;
		sh = 8'h00;
	end
	// start or repeated start
	always @(negedge sda) begin
		if (scl) begin
			act = 1'b1;
			bitn = 0;
		end
	end
	always @(posedge sda) begin
		if (scl) act = 1'b0;
	end
	always @(posedge scl) begin
		if (act && bitn < 8) begin
			sh = {sh[6:0], sda};
			bitn++;
		end
	end
	always @(negedge scl) begin
		if (act && bitn == 8) begin
			pull = !nack;
			rx_byte = sh;
			rx_cnt++;
			bitn = 9;
		end else if (bitn == 9) begin
			pull = 1'b0;
			bitn = 0;
		end
	end
endmodule

// [testbench.sv]
// self-checking bench for the two-wire master transmitter
`timescale 1ns/100ps
module testbench;
	import tw_pkg::*;
	localparam int unsigned HC = 8;
	logic pclk, presetn, psel, penable, pwrite, nack, mon, clash;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, r;
	logic pready, pslverr, scl_oe, sda_oe, spull, scl, sda;
	logic [7:0] rxb, lf, adr;
	int rxc, errors, check_count;
	logic [7:0] exq[$];
	// open-drain wires with pull-ups
	assign scl = !scl_oe;
	// clash models a second master pulling the data line low
	assign sda = !(sda_oe || spull || clash);
	tw_master #(.HALF_CYCLES(HC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
		.sda_in(sda), .sda_out(), .sda_oe(sda_oe));
	tw_slave slv_u (.scl(scl), .sda(sda), .nack(nack), .pull(spull), .rx_byte(rxb),
		.rx_cnt(rxc));
	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input string n, input logic [7:0] g);
		logic [7:0] e;
		e = exq.pop_front();
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_of_test();
		if (errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && mon) chk("prdata", prdata[7:0]);
	end
	always @(rxc) chk("rx_byte", rxb);
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		mon <= c;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		mon <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exq.push_back(e);
		apb(1'b0, a, 32'h0000_0000, 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h00_0000, d}, 1'b0);
	endtask
	task automatic wait_ctl(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, OFF_CONTROL, 32'h0000_0000, 1'b0);
			n++;
		end while (r[b] !== v && n < 400);
		if (n >= 400) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", "poll", v, r[b]);
		end
	endtask
	task automatic byte_tx(input logic [7:0] d, input logic [7:0] s);
		exq.push_back(d);
		wr(OFF_DATA, d);
		wr(OFF_CONTROL, 8'h84);
		wait_ctl(CTL_FLAG, 1'b1);
		rd(OFF_STATUS, s);
	endtask
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		#100000;
		errors++;
		end_of_test();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		nack = 1'b0;
		mon = 1'b0;
		clash = 1'b0;
		errors = 0;
		check_count = 0;
		lf = 8'h05;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_CONTROL, CTL_RESET);
		rd(OFF_STATUS, SC_IDLE);
		rd(8'h10, 8'h00);
		wr(OFF_STATUS, 8'h03);
		rd(OFF_STATUS, SC_IDLE | 8'h03);
		wr(OFF_STATUS, 8'h00);
		wr(OFF_DATA, 8'h5A);
		rd(OFF_CONTROL, 8'h08);
		wr(OFF_CONTROL, 8'hA4);
		wait_ctl(CTL_FLAG, 1'b1);
		rd(OFF_STATUS, SC_START);
		lf = nx(lf);
		adr = lf & 8'hFE;
		byte_tx(adr, SC_ADDR_ACK);
		rd(OFF_MODE, {6'h00, MODE_MT});
		wr(OFF_CONTROL, 8'h45);
		rd(OFF_CONTROL, 8'hC5);
		for (int i = 0; i < 2; i++) begin
			lf = nx(lf);
			nack <= i[0];
			byte_tx(lf, i[0] ? SC_DATA_NACK : SC_DATA_ACK);
		end
		nack <= 1'b1;
		wr(OFF_CONTROL, 8'hA4);
		wait_ctl(CTL_FLAG, 1'b1);
		rd(OFF_STATUS, SC_RSTART);
		byte_tx(adr | 8'h01, SC_ADDR_NACK);
		rd(OFF_MODE, {6'h00, MODE_MR});
		wr(OFF_CONTROL, 8'hB4);
		wait_ctl(CTL_FLAG, 1'b1);
		rd(OFF_STATUS, SC_START);
		// another master holds data low while the first bit sent is a one
		clash <= 1'b1;
		lf = nx(lf);
		wr(OFF_DATA, lf | 8'h80);
		wr(OFF_CONTROL, 8'h84);
		wait_ctl(CTL_FLAG, 1'b1);
		rd(OFF_STATUS, SC_ARB_LOST);
		rd(OFF_MODE, {6'h00, MODE_IDLE});
		clash <= 1'b0;
		wr(OFF_CONTROL, 8'hA4);
		wait_ctl(CTL_FLAG, 1'b1);
		rd(OFF_STATUS, SC_START);
		wr(OFF_CONTROL, 8'h94);
		wait_ctl(CTL_STOP, 1'b0);
		rd(OFF_CONTROL, 8'h04);
		wr(OFF_CONTROL, 8'hA4);
		wr(OFF_CONTROL, 8'h00);
		repeat (4 * HC) @(posedge pclk);
		exq.push_back(8'h03);
		chk("lines", {6'h00, scl, sda});
		end_of_test();
	end
endmodule
